// ==== fdpr_byte_lookup.sv ====
// byte lookup of the discovery table by relative address
`timescale 1ns/1ps
module fdpr_byte_lookup #(
   // identity byte of the vendor header, value is arbitrary
   parameter logic [7:0] VENDOR_ID = 8'h00
) (
   input  wire logic [23:0] addr_i,
   output logic      [7:0]  byte_o
);

   logic [7:0]  word_ofs;
   logic [31:0] dword;

   // lsb lane first within each doubleword
   function automatic logic [7:0] lane_of(input logic [31:0] dw,
                                          input logic [1:0]  lane);
      lane_of = 8'(dw >> {lane, 3'h0}); // RQ21
   endfunction

   always_comb begin
      word_ofs = {addr_i[7:2], 2'h0};
      dword    = {4{fdpr_pkg::FILL_BYTE}};
      // rest of the table and undefined space read as all ones
      if (addr_i[23:8] == fdpr_pkg::HI_ZERO) begin
         case (word_ofs)
            fdpr_pkg::HDR_SIG_OFS: dword = fdpr_pkg::HDR_SIG_DW;
            fdpr_pkg::HDR_REV_OFS: dword = fdpr_pkg::HDR_REV_DW;
            fdpr_pkg::PH0_DW1_OFS: dword = fdpr_pkg::PH0_DW1; // RQ20
            fdpr_pkg::PH0_DW2_OFS: dword = fdpr_pkg::PH0_DW2; // RQ20
            fdpr_pkg::PH1_DW1_OFS: dword = {fdpr_pkg::VEND_LEN,
               fdpr_pkg::VEND_MAJOR, fdpr_pkg::VEND_MINOR, VENDOR_ID};
            fdpr_pkg::PH1_DW2_OFS: dword = fdpr_pkg::PH1_DW2;
            fdpr_pkg::CAPS_OFS:    dword = fdpr_pkg::CAPS_VAL; // RQ1
            fdpr_pkg::DENSITY_OFS: dword = fdpr_pkg::DENSITY_VAL; // RQ7
            fdpr_pkg::QUAD_OFS:    dword = fdpr_pkg::QUAD_VAL; // RQ8
            fdpr_pkg::DUAL_OFS:    dword = fdpr_pkg::DUAL_VAL; // RQ12
            fdpr_pkg::FULL_OFS:    dword = fdpr_pkg::FULL_VAL; // RQ16
            fdpr_pkg::TWO_OFS:     dword = fdpr_pkg::TWO_VAL; // RQ18
            default:               dword = {4{fdpr_pkg::FILL_BYTE}};
         endcase
      end
      byte_o = lane_of(dword, addr_i[1:0]);
   end

endmodule // fdpr_byte_lookup

// ==== fdpr_discovery_rom.sv ====
// discovery parameter table read port with byte streaming
`timescale 1ns/1ps

// Summary of operation
// RQ1: byte 30h is E5h, uniform 4K erase
// RQ2: byte 30h bit 2 flags large buffer
// RQ3: byte 30h bits 4:3 read 00b
// RQ4: byte 31h is 4K erase opcode 20h
// RQ5: byte 32h is F9h, read modes, 3-byte
// RQ6: byte 33h unused, reads FFh
// RQ7: bytes 34h-37h give density 07FFFFFFh
// RQ8: byte 38h is 44h, quad-io timing
// RQ9: byte 39h is quad-io opcode EBh
// RQ10: byte 3Ah is 08h, quad-out timing
// RQ11: byte 3Bh is quad-out opcode 6Bh
// RQ12: byte 3Ch is 08h, dual-out timing
// RQ13: byte 3Dh is dual-out opcode 3Bh
// RQ14: byte 3Eh is 80h, dual-io timing
// RQ15: byte 3Fh is dual-io opcode BBh
// RQ16: byte 40h is FEh, four-line yes, two-line no
// RQ17: bytes 41h to 45h read FFh
// RQ18: bytes 46h and 47h read FFh
// RQ19: host fetches table with read opcode 5Ah
// RQ20: header points to 30h, length 10h
// RQ21: streaming reads increment, lsb byte first
module fdpr_discovery_rom #(
   parameter logic [7:0] VENDOR_ID = 8'h00 // arbitrary value
) (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   input  wire logic        rd_start_i,
   input  wire logic [23:0] rd_addr_i,
   input  wire logic        rd_next_i,
   input  wire logic        rd_stop_i,
   output logic      [7:0]  rd_data_o,
   output logic      [23:0] rd_addr_o,
   output logic             rd_valid_o,
   output logic             rd_busy_o,
   output logic      [31:0] rd_dword_o,
   output logic             rd_dword_valid_o
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   fdpr_pkg::fdpr_state_t state_reg;
   fdpr_pkg::fdpr_state_t state_next;
   logic [23:0] addr_reg;
   logic [23:0] addr_next;
   logic [7:0]  data_reg;
   logic [7:0]  data_next;
   logic        valid_reg;
   logic        valid_next;
   logic        fetch;
   logic [23:0] fetch_addr;
   logic [7:0]  lut_byte;
   logic [31:0] asm_reg;
   logic [31:0] asm_next;
   logic [2:0]  run_reg;
   logic [2:0]  run_next;
   logic [31:0] dword_reg;
   logic [31:0] dword_next;
   logic        dvalid_reg;
   logic        dvalid_next;
   logic [1:0]  lane;
   logic        step_reg;
   logic        step_next;

   // ****************************************************************
   // table lookup
   // ****************************************************************
   fdpr_byte_lookup #(
      .VENDOR_ID (VENDOR_ID)
   ) u_lookup (
      .addr_i    (fetch_addr),
      .byte_o    (lut_byte)
   );

   // ****************************************************************
   // read sequencing
   // ****************************************************************
   // a start always restarts, even mid-stream, so a host that lost
   // its place can resynchronise without a stop first
   always_comb begin
      state_next = state_reg;
      addr_next  = addr_reg;
      data_next  = data_reg;
      valid_next = 1'b0;
      fetch      = 1'b0;
      fetch_addr = addr_reg;
      step_next  = 1'b0;
      if (rd_start_i) begin
         state_next = fdpr_pkg::FDPR_STREAM; // RQ19
         fetch      = 1'b1;
         fetch_addr = rd_addr_i;
      end else if (rd_stop_i) begin
         state_next = fdpr_pkg::FDPR_IDLE;
      end else begin
         unique case (state_reg)
            fdpr_pkg::FDPR_IDLE: begin
               fetch = 1'b0;
            end
            fdpr_pkg::FDPR_STREAM: begin
               if (rd_next_i) begin
                  fetch      = 1'b1;
                  fetch_addr = 24'(addr_reg + 1'b1); // RQ21
                  step_next  = 1'b1;
               end
            end
         endcase
      end
      if (fetch) begin
         addr_next  = fetch_addr;
         data_next  = lut_byte;
         valid_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_reg <= fdpr_pkg::FDPR_IDLE;
         addr_reg  <= '0;
         data_reg  <= '0;
         valid_reg <= 1'b0;
         step_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         addr_reg  <= addr_next;
         data_reg  <= data_next;
         valid_reg <= valid_next;
         step_reg  <= step_next;
      end
   end

   // ****************************************************************
   // doubleword assembly
   // ****************************************************************
   // only four in-order bytes starting on lane 0 form a doubleword;
   // any skip or restart drops the partial word
   always_comb begin
      lane        = addr_reg[1:0];
      asm_next    = asm_reg;
      run_next    = run_reg;
      dword_next  = dword_reg;
      dvalid_next = 1'b0;
      if (valid_reg) begin
         asm_next = {data_reg, asm_reg[31:8]}; // RQ21
         if (lane == 2'h0) begin
            run_next = 3'h1;
         end else if (step_reg && run_reg == {1'b0, lane}) begin
            run_next = 3'(run_reg + 1'b1);
         end else begin
            run_next = 3'h0;
         end
         // a run left over from an earlier stream must not complete
         if (lane == 2'h3 && step_reg && run_reg == 3'h3) begin
            dword_next  = {data_reg, asm_reg[31:8]};
            dvalid_next = 1'b1;
            run_next    = 3'h0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         asm_reg    <= '0;
         run_reg    <= '0;
         dword_reg  <= '0;
         dvalid_reg <= 1'b0;
      end else begin
         asm_reg    <= asm_next;
         run_reg    <= run_next;
         dword_reg  <= dword_next;
         dvalid_reg <= dvalid_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign rd_data_o        = data_reg;
   assign rd_addr_o        = addr_reg;
   assign rd_valid_o       = valid_reg;
   assign rd_busy_o        = (state_reg == fdpr_pkg::FDPR_STREAM);
   assign rd_dword_o       = dword_reg;
   assign rd_dword_valid_o = dvalid_reg;

   // ****************************************************************
   // assertions
   // ****************************************************************
   function automatic logic hit(input logic [7:0] ofs,
                                input logic [1:0] ln);
      hit = valid_reg &&
            (addr_reg == {fdpr_pkg::HI_ZERO, ofs[7:2], ln});
   endfunction

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   a_erase_gran: assert property ( // RQ1
      hit(fdpr_pkg::CAPS_OFS, 2'h0) |->
         rd_data_o[1:0] == fdpr_pkg::ERASE_GRAN &&
         rd_data_o[7:5] == fdpr_pkg::UNUSED3)
      else $error("erase granularity byte wrong");
   a_buffer_flag: assert property ( // RQ2
      hit(fdpr_pkg::CAPS_OFS, 2'h0) |->
         rd_data_o[2] == fdpr_pkg::BUF_GT64)
      else $error("write buffer flag wrong");
   a_status_enc: assert property ( // RQ3
      hit(fdpr_pkg::CAPS_OFS, 2'h0) |->
         rd_data_o[4:3] == fdpr_pkg::VSR_WR)
      else $error("status write encoding wrong");
   a_erase_op: assert property ( // RQ4
      hit(fdpr_pkg::CAPS_OFS, 2'h1) |->
         rd_data_o == fdpr_pkg::ERASE4K_OP)
      else $error("erase opcode wrong");
   a_read_modes: assert property ( // RQ5
      hit(fdpr_pkg::CAPS_OFS, 2'h2) |->
         rd_data_o[6:4] == {fdpr_pkg::QOR_SUP, fdpr_pkg::QIO_SUP,
                            fdpr_pkg::DIO_SUP} &&
         rd_data_o[3] == fdpr_pkg::DTR_SUP &&
         rd_data_o[2:1] == fdpr_pkg::ADDR_BYTES &&
         rd_data_o[0] == fdpr_pkg::SIO_SUP)
      else $error("read mode support byte wrong");
   a_caps_top: assert property ( // RQ6
      hit(fdpr_pkg::CAPS_OFS, 2'h3) |->
         rd_data_o == fdpr_pkg::FILL_BYTE)
      else $error("unused caps byte not all ones");
   a_density_word: assert property ( // RQ7
      hit(fdpr_pkg::DENSITY_OFS, 2'h0) ##1
      hit(fdpr_pkg::DENSITY_OFS, 2'h1) && step_reg ##1
      hit(fdpr_pkg::DENSITY_OFS, 2'h2) && step_reg ##1
      hit(fdpr_pkg::DENSITY_OFS, 2'h3) && step_reg |=>
         rd_dword_valid_o && rd_dword_o == fdpr_pkg::DENSITY_VAL)
      else $error("density doubleword wrong");
   a_qio_timing: assert property ( // RQ8
      hit(fdpr_pkg::QUAD_OFS, 2'h0) |->
         rd_data_o == {fdpr_pkg::QIO_MODE, fdpr_pkg::QIO_DUMMY})
      else $error("quad io timing wrong");
   a_qio_op: assert property ( // RQ9
      hit(fdpr_pkg::QUAD_OFS, 2'h1) |-> rd_data_o == fdpr_pkg::QIO_OP)
      else $error("quad io opcode wrong");
   a_qor_timing: assert property ( // RQ10
      hit(fdpr_pkg::QUAD_OFS, 2'h2) |->
         rd_data_o == {fdpr_pkg::QOR_MODE, fdpr_pkg::QOR_DUMMY})
      else $error("quad out timing wrong");
   a_qor_op: assert property ( // RQ11
      hit(fdpr_pkg::QUAD_OFS, 2'h3) |-> rd_data_o == fdpr_pkg::QOR_OP)
      else $error("quad out opcode wrong");
   a_dor_timing: assert property ( // RQ12
      hit(fdpr_pkg::DUAL_OFS, 2'h0) |->
         rd_data_o == {fdpr_pkg::DOR_MODE, fdpr_pkg::DOR_DUMMY})
      else $error("dual out timing wrong");
   a_dor_op: assert property ( // RQ13
      hit(fdpr_pkg::DUAL_OFS, 2'h1) |-> rd_data_o == fdpr_pkg::DOR_OP)
      else $error("dual out opcode wrong");
   a_dio_timing: assert property ( // RQ14
      hit(fdpr_pkg::DUAL_OFS, 2'h2) |->
         rd_data_o == {fdpr_pkg::DIOR_MODE, fdpr_pkg::DIOR_DUMMY})
      else $error("dual io timing wrong");
   a_dio_op: assert property ( // RQ15
      hit(fdpr_pkg::DUAL_OFS, 2'h3) |-> rd_data_o == fdpr_pkg::DIOR_OP)
      else $error("dual io opcode wrong");
   a_four_line: assert property ( // RQ16
      hit(fdpr_pkg::FULL_OFS, 2'h0) |->
         rd_data_o[4] == fdpr_pkg::FLCM_SUP &&
         rd_data_o[0] == fdpr_pkg::DUAL_ALL_SUP &&
         rd_data_o[7:5] == fdpr_pkg::RFU3)
      else $error("full width support byte wrong");
   a_reserved_ones: assert property ( // RQ17
      hit(fdpr_pkg::FULL_OFS, 2'h1) || hit(fdpr_pkg::FULL_OFS, 2'h2) ||
      hit(fdpr_pkg::FULL_OFS, 2'h3) || hit(fdpr_pkg::TWO_OFS, 2'h0) ||
      hit(fdpr_pkg::TWO_OFS, 2'h1) |->
         rd_data_o == fdpr_pkg::FILL_BYTE)
      else $error("reserved byte not all ones");
   a_two_line: assert property ( // RQ18
      hit(fdpr_pkg::TWO_OFS, 2'h2) || hit(fdpr_pkg::TWO_OFS, 2'h3) |->
         rd_data_o == fdpr_pkg::FILL_BYTE)
      else $error("two line read bytes not all ones");
   a_start_latency: assert property ( // RQ19
      rd_start_i |=> rd_valid_o && rd_busy_o &&
         rd_addr_o == $past(rd_addr_i))
      else $error("start not answered next cycle");
   a_header_ptr: assert property ( // RQ20
      hit(fdpr_pkg::PH0_DW2_OFS, 2'h0) |->
         rd_data_o == fdpr_pkg::BFPT_OFS)
      else $error("table pointer wrong");
   a_header_len: assert property ( // RQ20
      hit(fdpr_pkg::PH0_DW1_OFS, 2'h3) |->
         rd_data_o == fdpr_pkg::BFPT_LEN_DW)
      else $error("table length wrong");
   a_addr_step: assert property ( // RQ21
      rd_busy_o && rd_next_i && !rd_start_i && !rd_stop_i |=>
         rd_valid_o && rd_addr_o == 24'($past(rd_addr_o) + 1'b1))
      else $error("stream address did not increment");
   a_idle_quiet: assert property (
      !rd_busy_o && !rd_start_i |=> !rd_valid_o [*2] or rd_start_i)
      else $error("data given while idle");

endmodule // fdpr_discovery_rom

// ==== fdpr_host_model.sv ====
// host-side model that reads the discovery table through the read port
`timescale 1ns/1ps
module fdpr_host_model (
   input  wire logic        sys_clk_i,
   output logic             rd_start_o,
   output logic      [23:0] rd_addr_o,
   output logic             rd_next_o,
   output logic             rd_stop_o
);
   // ****************************************************************
   // request driving
   // ****************************************************************
   initial begin
      rd_start_o = 1'b0;
      rd_addr_o  = 24'h000000;
      rd_next_o  = 1'b0;
      rd_stop_o  = 1'b0;
   end

   // one request cycle; address only qualified by start, else scrambled
   task automatic cyc(input logic s, input logic n, input logic p,
                      input logic [23:0] a);
      @(posedge sys_clk_i);
      rd_start_o <= s;
      rd_next_o  <= n;
      rd_stop_o  <= p;
      rd_addr_o  <= s ? a : ~rd_addr_o;
   endtask

   // read of len bytes from a; idle gaps between fetches model a slow host
   task automatic read_cmd(input logic [7:0] opcode,
                           input logic [23:0] a,
                           input int len, input int gap);
      if (opcode == 8'h5a) begin
         cyc(1'b1, 1'b0, 1'b0, a);
         for (int i = 1; i < len; i++) begin
            repeat (gap) cyc(1'b0, 1'b0, 1'b0, 24'h000000);
            cyc(1'b0, 1'b1, 1'b0, 24'h000000);
         end
         cyc(1'b0, 1'b0, 1'b1, 24'h000000);
         cyc(1'b0, 1'b0, 1'b0, 24'h000000);
      end
   endtask
endmodule // fdpr_host_model

// ==== fdpr_pkg.sv ====
// constants and field layouts of the flash discovery parameter table
package fdpr_pkg;

   // ****************************************************************
   // address space
   // ****************************************************************
   localparam int          ADDR_W    = 24;
   localparam logic [15:0] HI_ZERO   = 16'h0000;
   localparam logic [7:0]  FILL_BYTE = 8'hff;

   // ****************************************************************
   // header offsets and words, least significant byte first
   // ****************************************************************
   localparam logic [7:0]  HDR_SIG_OFS = 8'h00;
   localparam logic [7:0]  HDR_REV_OFS = 8'h04;
   localparam logic [7:0]  PH0_DW1_OFS = 8'h08;
   localparam logic [7:0]  PH0_DW2_OFS = 8'h0c;
   localparam logic [7:0]  PH1_DW1_OFS = 8'h10;
   localparam logic [7:0]  PH1_DW2_OFS = 8'h14;
   localparam logic [31:0] HDR_SIG_DW  = 32'h50444653;
   localparam logic [31:0] HDR_REV_DW  = 32'hff010108;
   localparam logic [7:0]  BFPT_OFS    = 8'h30;
   localparam logic [7:0]  BFPT_LEN_DW = 8'h10;
   localparam logic [7:0]  BFPT_MINOR  = 8'h07;
   localparam logic [7:0]  BFPT_MAJOR  = 8'h01;
   localparam logic [7:0]  BFPT_ID_LSB = 8'h00;
   localparam logic [7:0]  ID_MSB      = 8'hff;
   localparam logic [15:0] PTR_HI      = 16'h0000;
   localparam logic [31:0] PH0_DW1 =
      {BFPT_LEN_DW, BFPT_MAJOR, BFPT_MINOR, BFPT_ID_LSB};
   localparam logic [31:0] PH0_DW2 = {ID_MSB, PTR_HI, BFPT_OFS};
   localparam logic [7:0]  VEND_LEN   = 8'h03;
   localparam logic [7:0]  VEND_MAJOR = 8'h01;
   localparam logic [7:0]  VEND_MINOR = 8'h00;
   localparam logic [7:0]  VEND_OFS   = 8'h70;
   localparam logic [31:0] PH1_DW2 = {ID_MSB, PTR_HI, VEND_OFS};

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] CAPS_OFS    = 8'h30;
   localparam logic [7:0] DENSITY_OFS = 8'h34;
   localparam logic [7:0] QUAD_OFS    = 8'h38;
   localparam logic [7:0] DUAL_OFS    = 8'h3c;
   localparam logic [7:0] FULL_OFS    = 8'h40;
   localparam logic [7:0] TWO_OFS     = 8'h44;

   // ****************************************************************
   // erase_and_read_mode_caps fields
   // ****************************************************************
   localparam logic [1:0] ERASE_GRAN = 2'h1;
   localparam logic       BUF_GT64   = 1'b1;
   localparam logic [1:0] VSR_WR     = 2'h0;
   localparam logic [2:0] UNUSED3    = 3'h7;
   localparam logic [7:0] ERASE4K_OP = 8'h20;
   localparam logic       UNUSED1    = 1'b1;
   localparam logic       QOR_SUP    = 1'b1;
   localparam logic       QIO_SUP    = 1'b1;
   localparam logic       DIO_SUP    = 1'b1;
   localparam logic       DTR_SUP    = 1'b1;
   localparam logic [1:0] ADDR_BYTES = 2'h0;
   localparam logic       SIO_SUP    = 1'b1;
   localparam logic [31:0] CAPS_VAL = {FILL_BYTE, UNUSED1, QOR_SUP,
      QIO_SUP, DIO_SUP, DTR_SUP, ADDR_BYTES, SIO_SUP, ERASE4K_OP,
      UNUSED3, VSR_WR, BUF_GT64, ERASE_GRAN};

   // ****************************************************************
   // density and read timing fields
   // ****************************************************************
   localparam logic [31:0] DENSITY_VAL = 32'h07ffffff;
   localparam logic [2:0] QIO_MODE   = 3'h2;
   localparam logic [4:0] QIO_DUMMY  = 5'h04;
   localparam logic [7:0] QIO_OP     = 8'heb;
   localparam logic [2:0] QOR_MODE   = 3'h0;
   localparam logic [4:0] QOR_DUMMY  = 5'h08;
   localparam logic [7:0] QOR_OP     = 8'h6b;
   localparam logic [2:0] DOR_MODE   = 3'h0;
   localparam logic [4:0] DOR_DUMMY  = 5'h08;
   localparam logic [7:0] DOR_OP     = 8'h3b;
   localparam logic [2:0] DIOR_MODE  = 3'h4;
   localparam logic [4:0] DIOR_DUMMY = 5'h00;
   localparam logic [7:0] DIOR_OP    = 8'hbb;
   localparam logic [31:0] QUAD_VAL = {QOR_OP, QOR_MODE, QOR_DUMMY,
      QIO_OP, QIO_MODE, QIO_DUMMY};
   localparam logic [31:0] DUAL_VAL = {DIOR_OP, DIOR_MODE, DIOR_DUMMY,
      DOR_OP, DOR_MODE, DOR_DUMMY};
   localparam logic [2:0]  RFU3         = 3'h7;
   localparam logic        FLCM_SUP     = 1'b1;
   localparam logic        DUAL_ALL_SUP = 1'b0;
   localparam logic [23:0] RFU24        = 24'hffffff;
   localparam logic [31:0] FULL_VAL = {RFU24, RFU3, FLCM_SUP, RFU3,
      DUAL_ALL_SUP};
   localparam logic [2:0]  DUAL_ALL_MODE  = 3'h7;
   localparam logic [4:0]  DUAL_ALL_DUMMY = 5'h1f;
   localparam logic [7:0]  DUAL_ALL_OP    = 8'hff;
   localparam logic [15:0] RFU16          = 16'hffff;
   localparam logic [31:0] TWO_VAL = {DUAL_ALL_OP, DUAL_ALL_MODE,
      DUAL_ALL_DUMMY, RFU16};

   typedef enum logic {FDPR_IDLE, FDPR_STREAM} fdpr_state_t;

endpackage

// ==== test_flash_discovery_param_rom.sv ====
// self-checking bench of the discovery table read port
`timescale 1ns/1ps
module test_flash_discovery_param_rom;
   // arbitrary vendor identity for the header, value is arbitrary
   localparam logic [7:0] VEND_ID = 8'h3c;
   localparam logic [7:0] HDR [0:23] = '{
      8'h53, 8'h46, 8'h44, 8'h50, 8'h08, 8'h01, 8'h01, 8'hff,
      8'h00, 8'h07, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff,
      VEND_ID, 8'h00, 8'h01, 8'h03, 8'h70, 8'h00, 8'h00, 8'hff};
   localparam logic [7:0] TBL [0:23] = '{
      8'he5, 8'h20, 8'hf9, 8'hff,
      8'hff, 8'hff, 8'hff, 8'h07,
      8'h44, 8'heb, 8'h08, 8'h6b,
      8'h08, 8'h3b, 8'h80, 8'hbb,
      8'hfe, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff};

   logic        sys_clk_i;
   logic        reset_i;
   logic        rd_start_i;
   logic [23:0] rd_addr_i;
   logic        rd_next_i;
   logic        rd_stop_i;
   logic [7:0]  rd_data_o;
   logic [23:0] rd_addr_o;
   logic        rd_valid_o;
   logic        rd_busy_o;
   logic [31:0] rd_dword_o;
   logic        rd_dword_valid_o;
   int          mismatches;
   int          comparisons;
   int          nbytes;
   int          ndw;
   int          cycles;
   integer      seed;
   logic [23:0] exp_next;
   logic [23:0] dw_base;

   fdpr_discovery_rom #(.VENDOR_ID(VEND_ID)) fdpr_discovery_rom_inst (
      .sys_clk_i        (sys_clk_i),
      .reset_i          (reset_i),
      .rd_start_i       (rd_start_i),
      .rd_addr_i        (rd_addr_i),
      .rd_next_i        (rd_next_i),
      .rd_stop_i        (rd_stop_i),
      .rd_data_o        (rd_data_o),
      .rd_addr_o        (rd_addr_o),
      .rd_valid_o       (rd_valid_o),
      .rd_busy_o        (rd_busy_o),
      .rd_dword_o       (rd_dword_o),
      .rd_dword_valid_o (rd_dword_valid_o)
   );

   fdpr_host_model fdpr_host_model_inst (
      .sys_clk_i  (sys_clk_i),
      .rd_start_o (rd_start_i),
      .rd_addr_o  (rd_addr_i),
      .rd_next_o  (rd_next_i),
      .rd_stop_o  (rd_stop_i)
   );

   // ****************************************************************
   // expectations and compares
   // ****************************************************************
   function automatic logic [7:0] exp_byte(input logic [23:0] a);
      if (a < 24'h000018)
         return HDR[a[4:0]];
      if (a >= 24'h000030 && a < 24'h000048)
         return TBL[a[4:0] - 5'h10];
      return 8'hff;
   endfunction

   function automatic logic [31:0] exp_word(input logic [23:0] b);
      return {exp_byte(b + 24'h3), exp_byte(b + 24'h2),
              exp_byte(b + 24'h1), exp_byte(b)};
   endfunction

   task automatic miss(input string what);
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
   endtask

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                             input string what);
      comparisons++;
      if (got !== exp) miss($sformatf("%s %h /= %h", what, got, exp));
   endtask

   task automatic check_addr(input logic [23:0] got,
                             input logic [23:0] exp, input string what);
      comparisons++;
      if (got !== exp) miss($sformatf("%s %h /= %h", what, got, exp));
   endtask

   task automatic check_word(input logic [31:0] got,
                             input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) miss($sformatf("%s %h /= %h", what, got, exp));
   endtask

   task automatic check_cnt(input int got, input int exp,
                            input string what);
      comparisons++;
      if (got != exp) miss($sformatf("%s %0d /= %0d", what, got, exp));
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ****************************************************************
   // clock, monitor and timeout
   // ****************************************************************
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   // registered outputs are sampled at the edge after they were launched
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
      if (rd_dword_valid_o === 1'b1) begin
         ndw++;
         check_word(rd_dword_o, exp_word(dw_base), "dword");
      end
      if (rd_valid_o === 1'b1) begin
         nbytes++;
         check_addr(rd_addr_o, exp_next, "addr");
         check_byte(rd_data_o, exp_byte(rd_addr_o), "data");
         check_byte({7'h00, rd_busy_o}, 8'h01, "busy");
         if (rd_addr_o[1:0] == 2'h3) dw_base = rd_addr_o - 24'h3;
         exp_next = rd_addr_o + 24'h1;
      end
      if (rd_start_i === 1'b1 && reset_i === 1'b0) exp_next = rd_addr_i;
   end

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic burst(input logic [23:0] a, input int len,
                        input int gap);
      int          exp_dw;
      logic [23:0] t;
      exp_dw = 0;
      for (int i = 3; i < len; i++) begin
         t = a + 24'(i);
         if (t[1:0] == 2'h3) exp_dw++;
      end
      nbytes = 0;
      ndw = 0;
      fdpr_host_model_inst.read_cmd(8'h5a, a, len, gap);
      repeat (3) @(posedge sys_clk_i);
      check_cnt(nbytes, len, "bytes");
      check_cnt(ndw, exp_dw, "dwords");
      check_byte({7'h00, rd_busy_o}, 8'h00, "idle busy");
   endtask

   task automatic reset_check();
      reset_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      @(posedge sys_clk_i);
      #1;
      check_byte(rd_data_o, 8'h00, "reset data");
      check_word(rd_dword_o, 32'h00000000, "reset dword");
      check_byte({6'h00, rd_busy_o, rd_valid_o}, 8'h00, "reset flags");
   endtask

   initial begin
      int len;
      logic [23:0] a;
      mismatches = 0;
      comparisons = 0;
      cycles = 0;
      seed = 27833;
      exp_next = 24'h000000;
      dw_base = 24'h000000;
      reset_i = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      reset_check();
      burst(24'h000000, 128, 0);
      reset_check();
      burst(24'h00002e, 26, 1);
      burst(24'hfffffd, 6, 0);
      burst(24'h000031, 4, 2);
      // next while idle and next beside stop must both be ignored
      nbytes = 0;
      fdpr_host_model_inst.cyc(1'b1, 1'b0, 1'b0, 24'h000038);
      fdpr_host_model_inst.cyc(1'b0, 1'b1, 1'b0, 24'h000000);
      fdpr_host_model_inst.cyc(1'b0, 1'b1, 1'b1, 24'h000000);
      fdpr_host_model_inst.cyc(1'b0, 1'b1, 1'b0, 24'h000000);
      fdpr_host_model_inst.cyc(1'b0, 1'b0, 1'b0, 24'h000000);
      repeat (3) @(posedge sys_clk_i);
      check_cnt(nbytes, 2, "refused next");
      // start reissued in mid-stream restarts the address sequence
      nbytes = 0;
      fdpr_host_model_inst.cyc(1'b1, 1'b0, 1'b0, 24'h000030);
      fdpr_host_model_inst.cyc(1'b0, 1'b1, 1'b0, 24'h000000);
      fdpr_host_model_inst.cyc(1'b1, 1'b0, 1'b0, 24'h000044);
      fdpr_host_model_inst.cyc(1'b0, 1'b1, 1'b0, 24'h000000);
      fdpr_host_model_inst.cyc(1'b0, 1'b0, 1'b1, 24'h000000);
      fdpr_host_model_inst.cyc(1'b0, 1'b0, 1'b0, 24'h000000);
      repeat (3) @(posedge sys_clk_i);
      check_cnt(nbytes, 4, "reissue");
      for (int i = 0; i < 24; i++) begin
         a = 24'($random(seed));
         if (i % 4 != 0) a = a & 24'h00007f;
         len = 1 + int'($unsigned($random(seed)) % 8);
         burst(a, len, int'($unsigned($random(seed)) % 3));
      end
      report_and_stop();
   end
endmodule // test_flash_discovery_param_rom
